// *** design/dma_fifo_throttle.sv ***
// Block-transfer engine throttled by transmit and receive FIFOs
//
// What this block does
// [R1] - Stop fetching from local memory once transmit FIFO is half-full.
// [R2] - Suspend fetching while receive FIFO is at or above half.
// [R3] - After a stall, continue bursts back to back with no data loss.
// [R4] - Engine reads and receiver writes share one memory port by arbiter.
// [R5] - Interrupt status holds completion indicator and complete bit.
// [R6] - Byte count register has a done flag set when count reaches zero.
// [R7] - Source address error register tracks current source address.
// [R8] - Multiple grant request asserted while transmit FIFO is half-full.
// [R9] - Separate transmit and receive FIFO enables; disabled FIFO holds data.
// [R10] - Looped data fills a disabled receive FIFO past half-full, up to full.
// [R11] - Status and sense report a stall when halted on a half-full FIFO.
// [R12] - At completion source address points one doubleword past last.
// [R13] - Far transition module loops bus data back unchanged.
// [R14] - Byte count split into 8, 16 or 32 doubleword bursts by strap.
// [R15] - Fetching resumes by itself once the blocking FIFO drains.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module dma_fifo_throttle
  import dma_pkg::*;
#(
  parameter int unsigned DEPTH = dma_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [1:0]               subblock_strap,
  // AXI4-Lite slave
  input  wire logic [7:0]               awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  output logic                          irq,
  // Shared mezzanine memory port
  output logic                          mem_req,
  output logic                          mem_we,
  output logic [dma_pkg::ADDR_W-1:0]    mem_addr,
  output logic [dma_pkg::DATA_W-1:0]    mem_wdata,
  input  wire logic                     mem_gnt,
  input  wire logic [dma_pkg::DATA_W-1:0] mem_rdata,
  // Cluster bus toward the transition module
  output logic                          tx_valid,
  output logic [dma_pkg::DATA_W-1:0]    tx_data,
  input  wire logic                     tx_ready,
  output logic                          tx_last,
  input  wire logic                     rx_valid,
  input  wire logic [dma_pkg::DATA_W-1:0] rx_data,
  output logic                          rx_ready,
  output logic                          multiple_grant_request,
  // Receive-side memory destination
  input  wire logic [dma_pkg::ADDR_W-1:0] rx_dest_addr
);
  import dma_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dma_state_t        fsm;
    logic [31:0]       ctrl;
    logic [ADDR_W-1:0] src;
    logic [BC_W-1:0]   bc;
    logic              done;
    logic [1:0]        stat;
    logic [CI_W-1:0]   ci;
    logic [1:0]        mask;
    logic [5:0]        sub_left;
    logic              rd_pend;
    logic              rx_turn;
    logic              aw_hit;
    logic              w_hit;
    logic [7:0]        aw_q;
    logic [31:0]       w_q;
    logic              bv;
    logic              rv;
    logic [31:0]       rd_q;
    logic [1:0]        rr;
  } top_t;
  top_t st;
  top_t next_st;
  logic rst_q_b;
  // Kept apart from the state record so only one process writes each
  logic [1:0] rst_sync;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_q_b = rst_sync[1];

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic tx_in_valid;
  logic tx_in_ready;
  logic tx_hf;
  logic rx_out_valid;
  logic [DATA_W-1:0] rx_out_data;
  logic rx_hf;
  logic rx_rd;
  logic tx_rd;
  logic tx_ok;

  // Fetched word goes straight to the transmit FIFO, one in flight
  assign tx_in_valid = st.rd_pend && mem_gnt;
  assign tx_rd       = st.ctrl[CTRL_TX_EN] && tx_ready; // [R9]

  dma_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rst_b     (rst_q_b),
    .wr_valid  (tx_in_valid),
    .wr_data   (mem_rdata),
    .wr_ready  (tx_in_ready),
    .rd_en     (tx_rd),
    .rd_valid  (tx_ok),
    .rd_data   (tx_data),
    .half_full (tx_hf)
  );
  assign tx_valid = tx_ok && st.ctrl[CTRL_TX_EN];
  assign tx_last  = 1'b0;

  // Looped data keeps landing while reads are disabled [R10]
  dma_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst_b     (rst_q_b),
    .wr_valid  (rx_valid),
    .wr_data   (rx_data),
    .wr_ready  (rx_ready),
    .rd_en     (rx_rd),
    .rd_valid  (rx_out_valid),
    .rd_data   (rx_out_data),
    .half_full (rx_hf)
  );

  // Half-full only reported when bus control bit allows it [R8]
  assign multiple_grant_request = tx_hf && st.ctrl[CTRL_MULT];

  function automatic logic [5:0] sub_len(input logic [1:0] s);
    unique case (s)
      SUB_16:  sub_len = 6'd16;
      SUB_32:  sub_len = 6'd32;
      default: sub_len = 6'd8;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Memory arbitration and engine
  // ----------------------------------------------------------------
  logic blocked;
  logic rx_want;
  logic dma_want;
  logic grant_rx;
  logic aw_do;
  logic w_do;
  logic wr_go;
  logic [3:0] ev;

  assign blocked  = tx_hf || rx_hf;                    // [R1] [R2]
  assign rx_want  = rx_out_valid && st.ctrl[CTRL_RX_EN];
  assign dma_want = (st.fsm == S_RUN) && !blocked && !st.rd_pend;
  // Alternate owner on each grant so neither side starves [R4]
  assign grant_rx = rx_want && (!st.rd_pend) && (st.rx_turn || !dma_want);
  assign rx_rd    = grant_rx && mem_gnt;

  always_comb
  begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = st.src;
    mem_wdata = rx_out_data;
    if (grant_rx)
    begin
      mem_req  = 1'b1;
      mem_we   = 1'b1;
      mem_addr = rx_dest_addr;
    end
    else if (st.rd_pend || dma_want)
      mem_req = 1'b1;
  end

  assign aw_do = awvalid && !st.aw_hit;
  assign w_do  = wvalid && !st.w_hit;
  assign awready = !st.aw_hit;
  assign wready  = !st.w_hit;
  assign wr_go = (st.aw_hit || aw_do) && (st.w_hit || w_do) && !st.bv;

  always_comb
  begin
    logic [7:0]  wa;
    logic [31:0] wd;
    wa = st.aw_hit ? st.aw_q : awaddr;
    wd = st.w_hit ? st.w_q : wdata;
    ev = 4'h0;
    next_st = st;
    if (rx_rd || (st.rd_pend && mem_gnt))
      next_st.rx_turn = !st.rx_turn;
    unique case (st.fsm)
      S_IDLE:
      begin
        if (st.ctrl[CTRL_START] && st.bc != '0)
        begin
          next_st.fsm      = S_RUN;
          next_st.done     = 1'b0;
          next_st.sub_left = sub_len(subblock_strap);          // [R14]
        end
      end
      S_RUN, S_STALL:
      begin
        if (blocked && !st.rd_pend)
        begin
          next_st.fsm = S_STALL;                                // [R11]
          if (st.fsm == S_RUN)
            ev[ST_STALL] = 1'b1;
        end
        else
          next_st.fsm = S_RUN;                                  // [R15] [R3]
        if (dma_want && !grant_rx)
          next_st.rd_pend = 1'b1;
        if (st.rd_pend && mem_gnt && tx_in_ready)
        begin
          next_st.rd_pend = 1'b0;
          next_st.src = st.src + ADDR_W'(DW_BYTES);             // [R7] [R12]
          next_st.bc  = st.bc - DW_BYTES;
          next_st.sub_left = (st.sub_left == 6'd1)
                             ? sub_len(subblock_strap)          // [R14]
                             : st.sub_left - 6'd1;
          if (st.bc == DW_BYTES)
          begin
            next_st.fsm  = S_IDLE;
            next_st.done = 1'b1;                                // [R6]
            next_st.ctrl[CTRL_START] = 1'b0;
            next_st.ci = st.ci + 1'b1;                          // [R5]
            ev[ST_CMPLT] = 1'b1;
          end
        end
      end
      default:
        next_st.fsm = S_IDLE;
    endcase

    // Register writes
    if (aw_do)
    begin
      next_st.aw_hit = 1'b1;
      next_st.aw_q   = awaddr;
    end
    if (w_do)
    begin
      next_st.w_hit = 1'b1;
      next_st.w_q   = wdata;
    end
    if (wr_go)
    begin
      next_st.aw_hit = 1'b0;
      next_st.w_hit  = 1'b0;
      next_st.bv     = 1'b1;
      unique case (wa)
        OFS_CTRL:     next_st.ctrl = wd;
        OFS_SRC:      if (st.fsm == S_IDLE) next_st.src = wd;
        OFS_BC:       if (st.fsm == S_IDLE) next_st.bc = wd[BC_W-1:0];
        OFS_INT_STAT: next_st.stat = st.stat & ~wd[1:0];
        OFS_INT_MASK: next_st.mask = wd[1:0];
        default:      ;
      endcase
    end
    // Hardware set wins over software clear
    next_st.stat = next_st.stat | ev[1:0];                      // [R5] [R11]
    if (st.bv && bready)
      next_st.bv = 1'b0;

    // Register reads
    if (arvalid && !st.rv)
    begin
      next_st.rv = 1'b1;
      next_st.rr = RESP_OKAY;
      unique case (araddr)
        OFS_CTRL:     next_st.rd_q = st.ctrl;
        OFS_SRC:      next_st.rd_q = st.src;
        OFS_BC:       next_st.rd_q = {st.done, 11'h000, st.bc};  // [R6]
        OFS_SAE:      next_st.rd_q = st.src;                     // [R7]
        OFS_INT_STAT: next_st.rd_q = {20'h00000, st.ci, 6'h00, st.stat};
        OFS_INT_MASK: next_st.rd_q = {30'h0, st.mask};
        OFS_SENSE:    next_st.rd_q = {28'h0, rx_hf, tx_hf,
                                      st.fsm == S_STALL, st.fsm != S_IDLE};
        default:
        begin
          next_st.rd_q = ZERO_RST;
          next_st.rr   = RESP_SLVERR;
        end
      endcase
    end
    else if (st.rv && rready)
      next_st.rv = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_q_b)
  begin
    if (!rst_q_b)
    begin
      st.fsm      <= S_IDLE;
      st.ctrl     <= CTRL_RST;
      st.src      <= '0;
      st.bc       <= '0;
      st.done     <= 1'b0;
      st.stat     <= 2'h0;
      st.ci       <= '0;
      st.mask     <= 2'h0;
      st.sub_left <= 6'd8;
      st.rd_pend  <= 1'b0;
      st.rx_turn  <= 1'b0;
      st.aw_hit   <= 1'b0;
      st.w_hit    <= 1'b0;
      st.aw_q     <= 8'h00;
      st.w_q      <= ZERO_RST;
      st.bv       <= 1'b0;
      st.rv       <= 1'b0;
      st.rd_q     <= ZERO_RST;
      st.rr       <= RESP_OKAY;
    end
    else
    begin
      st.fsm      <= next_st.fsm;
      st.ctrl     <= next_st.ctrl;
      st.src      <= next_st.src;
      st.bc       <= next_st.bc;
      st.done     <= next_st.done;
      st.stat     <= next_st.stat;
      st.ci       <= next_st.ci;
      st.mask     <= next_st.mask;
      st.sub_left <= next_st.sub_left;
      st.rd_pend  <= next_st.rd_pend;
      st.rx_turn  <= next_st.rx_turn;
      st.aw_hit   <= next_st.aw_hit;
      st.w_hit    <= next_st.w_hit;
      st.aw_q     <= next_st.aw_q;
      st.w_q      <= next_st.w_q;
      st.bv       <= next_st.bv;
      st.rv       <= next_st.rv;
      st.rd_q     <= next_st.rd_q;
      st.rr       <= next_st.rr;
    end
  end

  assign bvalid  = st.bv;
  assign bresp   = RESP_OKAY;
  assign arready = !st.rv;
  assign rvalid  = st.rv;
  assign rdata   = st.rd_q;
  assign rresp   = st.rr;
  assign irq     = |(st.stat & st.mask);
endmodule // dma_fifo_throttle

// *** design/dma_pkg.sv ***
// Package of constants for the throttled block-transfer engine
package dma_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned BC_W        = 20;
  localparam int unsigned FIFO_DEPTH  = 64;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SRC      = 8'h04;
  localparam logic [7:0] OFS_BC       = 8'h08;
  localparam logic [7:0] OFS_SAE      = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_SENSE    = 8'h18;
  // Control fields
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_TX_EN  = 1;
  localparam int unsigned CTRL_RX_EN  = 2;
  localparam int unsigned CTRL_MULT   = 3;
  // Status fields
  localparam int unsigned ST_CMPLT    = 0;
  localparam int unsigned ST_STALL    = 1;
  localparam int unsigned CI_LSB      = 8;
  localparam int unsigned CI_W        = 4;
  localparam int unsigned BC_DONE     = 31;
  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0006;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  // Burst sizes by strap, doublewords
  localparam logic [1:0] SUB_8        = 2'h0;
  localparam logic [1:0] SUB_16       = 2'h1;
  localparam logic [1:0] SUB_32       = 2'h2;
  localparam logic [BC_W-1:0] DW_BYTES = 20'h00008;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_STALL} dma_state_t;
endpackage

// *** design/dma_fifo.sv ***
// Simple synchronous FIFO with half-full flag and hold enable
`timescale 1ns/1ns
module dma_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 64
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  input  wire logic             rd_en,
  output logic                  rd_valid,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  half_full
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_t;
  fifo_t st;
  fifo_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign wr_ready  = st.cnt != (AW+1)'(DEPTH);
  assign rd_valid  = st.cnt != '0;
  assign rd_data   = mem[st.rp];
  assign half_full = st.cnt >= (AW+1)'(DEPTH/2);
  assign do_wr     = wr_valid && wr_ready;
  // A disabled reader holds contents, so the level climbs
  assign do_rd     = rd_en && rd_valid;

  always_comb
  begin
    next_st = st;
    if (do_wr)
      next_st.wp = st.wp + 1'b1;
    if (do_rd)
      next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[st.wp] <= wr_data;
  end
endmodule // dma_fifo

// *** dv/loop_partner.sv ***
// Behavioural transition module that loops transmit words back
`timescale 1ns/1ns
module loop_partner (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [31:0]      rx_data,
  input  wire logic        rx_ready
);
  // ---------------
  // Loopback store
  // ---------------
  logic [31:0] hold_q [4];
  logic [31:0] last;
  logic [2:0]  cnt;
  logic [1:0]  wp, rp;
  logic        slow;
  // Half-rate accept so the engine always meets back-pressure
  assign tx_ready = slow && (cnt < 3'h4);
  assign rx_valid = (cnt != 3'h0);
  // Idle line shows the inverse of the last word, never a stale copy
  assign rx_data = rx_valid ? hold_q[rp] : ~last;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 3'h0;
      wp <= 2'h0;
      rp <= 2'h0;
      slow <= 1'b0;
      last <= 32'h0000_0000;
    end
    else
    begin
      slow <= !slow;
      if (tx_valid && tx_ready)
        hold_q[wp] <= tx_data;
      wp <= wp + 2'(tx_valid && tx_ready);
      if (rx_valid && rx_ready)
        last <= hold_q[rp];
      rp <= rp + 2'(rx_valid && rx_ready);
      cnt <= cnt + 3'(tx_valid && tx_ready) - 3'(rx_valid && rx_ready);
    end
  end
endmodule // loop_partner

// *** dv/dma_fifo_throttle_properties.sv ***
// Port checks and bind for the throttled transfer engine
`timescale 1ns/1ns
module dma_fifo_throttle_properties (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_gnt
);
  import dma_pkg::*;
  // ------------------
  // Handshake checks
  // ------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid && bresp == RESP_OKAY)
    else $error("write not answered");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_holds: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_single: assert property (rvalid |-> !arready)
    else $error("second read taken");
  a_unmapped_err: assert property (
    arvalid && arready && araddr > OFS_SENSE
    |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (
    arvalid && arready && araddr <= OFS_SENSE && araddr[1:0] == 2'h0
    |=> rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_word_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit word lost");
  c_tx_stall: cover property (tx_valid && !tx_ready);
  c_rx_write: cover property (mem_req && mem_gnt && mem_we);
  c_bad_read: cover property (rvalid && rresp == RESP_SLVERR);
endmodule // dma_fifo_throttle_properties

bind dma_fifo_throttle dma_fifo_throttle_properties
  dma_fifo_throttle_properties_i (
  .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rresp(rresp), .rdata(rdata),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .mem_req(mem_req), .mem_we(mem_we), .mem_gnt(mem_gnt)
);

// *** dv/tb_top.sv ***
// Self-checking bench for the throttled transfer engine
`timescale 1ns/1ns
module tb_top;
  import dma_pkg::*;
  // ---------
  // Signals
  // ---------
  localparam logic [31:0] SRC_A = 32'h0000_1000;
  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, mem_req, mem_we;
  logic        mem_gnt, tx_valid, tx_ready, tx_last, rx_valid, rx_ready, mgr;
  logic [1:0]  strap, bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_wdata, tx_data, rx_data;
  logic [31:0] rd_val, seen, wr_base;
  int          miscompares = 0;
  int          total_checks = 0;
  int          wr_k = 0;
  int          cyc = 0;
  // Memory answers each read with its own address
  dma_fifo_throttle dma_fifo_throttle_i (
    .clk(clk), .rst_b(rst_b), .subblock_strap(strap), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_addr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .multiple_grant_request(mgr),
    .rx_dest_addr(32'h0000_8000)
  );
  loop_partner loop_partner_i (
    .clk(clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready)
  );
  // ---------
  // Helpers
  // ---------
  task automatic check(input string what, input logic [31:0] s,
                       input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic give_up(input int n);
    if (n >= 2000)
    begin
      miscompares++;
      $display("MISMATCH wait expected answer seen timeout");
      complete_run;
    end
  endtask
  // Grant three cycles in four so engine and receiver contend
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    mem_gnt <= (cyc % 4 != 3);
    if (mem_req && mem_gnt && mem_we)
    begin
      check("rx_word", mem_wdata, wr_base + 32'(wr_k) * 32'h8);
      wr_k = wr_k + 1;
    end
  end
  // Handshakes are judged on settled values at the falling edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_t;
    logic w_t;
    logic b_t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b_t = 1'b0;
    for (n = 0; n < 2000 && !b_t; n++)
    begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = (bvalid === 1'b1);
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    give_up(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic ar_t;
    logic r_t;
    araddr <= a;
    arvalid <= 1'b1;
    r_t = 1'b0;
    d = 32'h0000_0000;
    r = 2'h0;
    for (n = 0; n < 2000 && !r_t; n++)
    begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = (rvalid === 1'b1);
      if (r_t) d = rdata;
      if (r_t) r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end
    give_up(n);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] e);
    logic [1:0] r;
    axi_rd(a, rd_val, r);
    check(what, rd_val, e);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    logic [1:0] r;
    rd_val = 32'h0000_0000;
    for (n = 0; n < 2000 && (rd_val & m) !== m; n++)
      axi_rd(a, rd_val, r);
    give_up(n);
  endtask
  task automatic wait_words(input int w);
    int n;
    for (n = 0; n < 2000 && wr_k < w; n++)
      @(posedge clk);
    check("words", 32'(wr_k), 32'(w));
  endtask
  // -----------
  // Scenarios
  // -----------
  task automatic t_reset;
    logic [1:0] r;
    axi_wr(8'h20, 32'hFFFF_FFFF);
    rd_chk("ctrl", OFS_CTRL, CTRL_RST);
    for (int i = 1; i < 7; i++)
      rd_chk("reg_rst", 8'(i * 4), ZERO_RST);
    axi_rd(8'h1C, seen, r);
    check("bad_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("bad_data", seen, ZERO_RST);
  endtask
  task automatic t_tx_stall;
    axi_wr(OFS_CTRL, 32'h0000_0000);
    axi_wr(OFS_SRC, SRC_A);
    axi_wr(OFS_BC, 32'h0000_0200);
    axi_wr(OFS_CTRL, 32'h0000_0009);
    poll(OFS_INT_STAT, 32'h0000_0002);
    rd_chk("stop_addr", OFS_SAE, SRC_A + 32'h100);
    repeat (20) @(posedge clk);
    rd_chk("held_addr", OFS_SAE, SRC_A + 32'h100);
    rd_chk("sense", OFS_SENSE, 32'h0000_0007);
    check("mult", {31'h0, mgr}, 32'h0000_0001);
    check("irq_off", {31'h0, irq}, 32'h0000_0000);
    axi_wr(OFS_INT_MASK, 32'h0000_0002);
    check("irq_on", {31'h0, irq}, 32'h0000_0001);
    axi_wr(OFS_INT_STAT, 32'h0000_0002);
    check("irq_clr", {31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_rx_stall;
    logic [1:0] r;
    wr_base = SRC_A;
    wr_k = 0;
    axi_wr(OFS_CTRL, 32'h0000_000B);
    poll(OFS_SENSE, 32'h0000_0008);
    axi_rd(OFS_SAE, seen, r);
    repeat (20) @(posedge clk);
    rd_chk("rx_hold", OFS_SAE, seen);
    check("rx_kept", 32'(wr_k), 32'h0000_0000);
    axi_wr(OFS_CTRL, 32'h0000_000F);
    poll(OFS_INT_STAT, 32'h0000_0001);
    wait_words(64);
    rd_chk("end_addr", OFS_SAE, SRC_A + 32'h200);
    axi_rd(OFS_BC, seen, r);
    check("done", seen & 32'h8000_0000, 32'h8000_0000);
    axi_rd(OFS_INT_STAT, seen, r);
    check("indicator", seen & 32'h0000_0F01, 32'h0000_0101);
  endtask
  task automatic t_straps;
    for (int s = 0; s < 3; s++)
    begin
      strap <= 2'(s);
      wr_base = 32'h0000_2000;
      wr_k = 0;
      axi_wr(OFS_INT_STAT, 32'h0000_0FFF);
      axi_wr(OFS_SRC, 32'h0000_2000);
      axi_wr(OFS_BC, 32'h0000_0140);
      axi_wr(OFS_CTRL, 32'h0000_000F);
      poll(OFS_INT_STAT, 32'h0000_0001);
      wait_words(40);
      rd_chk("strap_addr", OFS_SAE, 32'h0000_2140);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, mem_gnt} = 7'h00;
    {strap, awaddr, araddr, wdata, wstrb} = 54'h0;
    wr_base = SRC_A;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wstrb <= 4'hF;
    // Responses are always accepted the edge they appear
    bready <= 1'b1;
    rready <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_tx_stall;
    t_rx_stall;
    t_straps;
    complete_run;
  end
endmodule // tb_top
